// [src/bwcs_pkg.sv]
package bwcs_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CLKMD_OFS = 8'h03;
  localparam logic [7:0] WAKEOPT_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h05;
  localparam logic [7:0] XCTL_OFS = 8'h0a;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int XCTL_EN_BIT = 7;
  localparam int XCTL_DRV_LO = 5;
  localparam int CLKMD_HEN_BIT = 4;
  localparam int CLKMD_LEN_BIT = 2;
  localparam int CLKMD_SRC_LO = 0;
  localparam int CLKMD_DIV_LO = 5;
  localparam int WAKEOPT_FAST_BIT = 0;
  // ****************************************
  // Source codes, reset values and address map
  // ****************************************
  localparam logic [1:0] SRC_HRC = 2'h0;
  localparam logic [1:0] SRC_LRC = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;
  localparam logic [2:0] DIV_RST = 3'h1;
  localparam logic [10:0] RESET_VEC = 11'h000;
  localparam logic [10:0] INT_VEC = 11'h010;
  localparam logic [10:0] SYS_AREA_LO = 11'h7e0;
  // ****************************************
  // Timing counts in low-speed rc periods, strap settle in mclk cycles
  // ****************************************
  localparam int FAST_CNT = 45;
  localparam int NORM_CNT = 3000;
  localparam int STRAP_SETTLE = 3;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    st_boot = 4'h1,
    st_run = 4'h2,
    st_sleep = 4'h4,
    st_wake = 4'h8
  } bwcs_st_t;
endpackage : bwcs_pkg

// [src/bwcs_dly_cnt.sv]
`timescale 1ns/1ps
module bwcs_dly_cnt #(
  parameter int CNT_W = 12
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic clr,
  input wire logic tick,
  input wire logic [CNT_W-1:0] limit,
  output logic [CNT_W-1:0] cnt,
  output logic done
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } bwcs_cnt_t;
  bwcs_cnt_t s_q;
  bwcs_cnt_t s_d;

  generate
    if (CNT_W < 12) begin : g_chk
      $error("bwcs_dly_cnt needs CNT_W of at least 12");
    end
  endgenerate

  assign cnt = s_q.cnt;
  assign done = tick && !clr && (s_q.cnt == limit - {{(CNT_W-1){1'b0}}, 1'b1});

  always_comb begin
    s_d = s_q;
    if (clr || done) begin
      s_d.cnt = '0;
    end else if (tick) begin
      s_d.cnt = s_q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule : bwcs_dly_cnt

// [src/bwcs_top.sv]
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Fast wake-up waits 45 slow periods
// - Normal wake-up waits 3000 slow periods
// - Boot holds core 45 or 3000 periods
// - Power-on reset restarts whole boot sequence
// - Core starts fetching at address 0x000
// - Interrupts vector to address 0x10
// - Top 32 words reserved for system
// - Three oscillator enables, independently controlled except the selected source stays on and lrc_en stays on while the core is not running
// - Software picks clock source and divider
// - Both rc oscillators running after boot
module bwcs_top (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic lrc_clk_in,
  input wire logic boot_fast_pin,
  input wire logic sleep_req,
  input wire logic wake_evt,
  input wire logic int_take,
  input wire logic [10:0] prog_addr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic core_rst_n,
  output logic core_run,
  output logic vec_load,
  output logic [10:0] vec_addr,
  output logic sys_area,
  output logic user_space,
  output logic xtal_en,
  output logic [1:0] xtal_drv,
  output logic hrc_en,
  output logic lrc_en,
  output logic [1:0] clk_src,
  output logic [2:0] clk_div
);
  typedef struct packed {
    bwcs_pkg::bwcs_st_t st;
    logic [2:0] lrc_s;
    logic [1:0] strap_s;
    logic [1:0] cap;
    logic boot_fast;
    logic wake_fast;
    logic xen;
    logic [1:0] xdrv;
    logic hen;
    logic len;
    logic [1:0] src;
    logic [2:0] div;
    logic [7:0] rdata;
    logic vload;
    logic [10:0] vaddr;
  } bwcs_state_t;
  bwcs_state_t s_q;
  bwcs_state_t s_d;

  logic tick;
  logic dly_clr;
  logic dly_done;
  logic [11:0] dly_limit;
  logic [11:0] dly_cnt;
  logic fast_sel;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic src_ok(input logic [1:0] s, input logic x, input logic h, input logic l);
    src_ok = (s == bwcs_pkg::SRC_XTAL) ? x : (s == bwcs_pkg::SRC_HRC) ? h : (s == bwcs_pkg::SRC_LRC) ? l : 1'b0;
  endfunction : src_ok

  function automatic logic in_sys(input logic [10:0] a);
    in_sys = (a >= bwcs_pkg::SYS_AREA_LO);
  endfunction : in_sys

  // ****************************************
  // Delay timing
  // ****************************************
  // Third sync flop only feeds the edge detector
  assign tick = s_q.lrc_s[1] && !s_q.lrc_s[2];
  assign fast_sel = (s_q.st == bwcs_pkg::st_boot) ? s_q.boot_fast : s_q.wake_fast;
  // Select boot or wake terminal count
  assign dly_limit = fast_sel ? 12'(bwcs_pkg::FAST_CNT) : 12'(bwcs_pkg::NORM_CNT);
  // Counting waits for the strap to settle
  assign dly_clr = !((s_q.st == bwcs_pkg::st_boot && s_q.cap == 2'(bwcs_pkg::STRAP_SETTLE))
    || s_q.st == bwcs_pkg::st_wake);

  bwcs_dly_cnt #(
    .CNT_W(12)
  ) u_dly (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .clr(dly_clr),
    .tick(tick),
    .limit(dly_limit),
    .cnt(dly_cnt),
    .done(dly_done)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic wr_ok;
    logic [1:0] nsrc;
    logic nx;
    logic nh;
    logic nl;
    wr_ok = 1'b0;
    nsrc = 2'h0;
    nx = 1'b0;
    nh = 1'b0;
    nl = 1'b0;
    s_d = s_q;
    s_d.lrc_s = {s_q.lrc_s[1:0], lrc_clk_in};
    s_d.strap_s = {s_q.strap_s[0], boot_fast_pin};
    s_d.vload = 1'b0;
    if (s_q.cap != 2'(bwcs_pkg::STRAP_SETTLE)) begin
      s_d.cap = s_q.cap + 2'h1;
      s_d.boot_fast = s_q.strap_s[1];
    end
    case (s_q.st)
      bwcs_pkg::st_boot: begin
        if (dly_done) begin
          s_d.st = bwcs_pkg::st_run;
          s_d.vload = 1'b1;
          s_d.vaddr = bwcs_pkg::RESET_VEC;
        end
      end
      bwcs_pkg::st_run: begin
        if (sleep_req) begin
          s_d.st = bwcs_pkg::st_sleep;
        end else if (int_take) begin
          s_d.vload = 1'b1;
          s_d.vaddr = bwcs_pkg::INT_VEC;
        end
      end
      bwcs_pkg::st_sleep: begin
        if (wake_evt) begin
          s_d.st = bwcs_pkg::st_wake;
        end
      end
      bwcs_pkg::st_wake: begin
        if (dly_done) begin
          s_d.st = bwcs_pkg::st_run;
        end
      end
      default: begin
        s_d.st = bwcs_pkg::st_boot;
      end
    endcase
    // Writes ignored while core is held, so boot ends with rc oscillators on
    wr_ok = reg_wr && (s_q.st != bwcs_pkg::st_boot);
    nx = s_q.xen;
    nh = s_q.hen;
    nl = s_q.len;
    nsrc = s_q.src;
    if (wr_ok && reg_addr == bwcs_pkg::XCTL_OFS) begin
      nx = reg_wdata[bwcs_pkg::XCTL_EN_BIT];
      s_d.xdrv = reg_wdata[bwcs_pkg::XCTL_DRV_LO +: 2];
    end
    if (wr_ok && reg_addr == bwcs_pkg::CLKMD_OFS) begin
      nh = reg_wdata[bwcs_pkg::CLKMD_HEN_BIT];
      nl = reg_wdata[bwcs_pkg::CLKMD_LEN_BIT];
      s_d.div = reg_wdata[bwcs_pkg::CLKMD_DIV_LO +: 3];
      // Refuse switch to a stopped oscillator
      if (src_ok(reg_wdata[bwcs_pkg::CLKMD_SRC_LO +: 2], nx, nh, nl)) begin
        nsrc = reg_wdata[bwcs_pkg::CLKMD_SRC_LO +: 2];
      end
    end
    // Active source cannot be switched off
    if (nsrc == bwcs_pkg::SRC_XTAL) begin
      nx = 1'b1;
    end
    if (nsrc == bwcs_pkg::SRC_HRC) begin
      nh = 1'b1;
    end
    if (nsrc == bwcs_pkg::SRC_LRC) begin
      nl = 1'b1;
    end
    s_d.xen = nx;
    s_d.hen = nh;
    s_d.len = nl;
    s_d.src = nsrc;
    if (wr_ok && reg_addr == bwcs_pkg::WAKEOPT_OFS) begin
      s_d.wake_fast = reg_wdata[bwcs_pkg::WAKEOPT_FAST_BIT];
    end
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        bwcs_pkg::XCTL_OFS: s_d.rdata = {s_q.xen, s_q.xdrv, 5'h00};
        bwcs_pkg::CLKMD_OFS: s_d.rdata = {s_q.div, s_q.hen, 1'b0, s_q.len, s_q.src};
        bwcs_pkg::WAKEOPT_OFS: s_d.rdata = {7'h00, s_q.wake_fast};
        bwcs_pkg::STATUS_OFS: s_d.rdata = {3'h0, s_q.boot_fast, s_q.st};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      // Power-on resets all and restarts boot
      s_q <= '0;
      s_q.st <= bwcs_pkg::st_boot;
      // Both rc oscillators on from reset
      s_q.hen <= 1'b1;
      s_q.len <= 1'b1;
      s_q.src <= bwcs_pkg::SRC_HRC;
      s_q.div <= bwcs_pkg::DIV_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = s_q.rdata;
  assign core_rst_n = (s_q.st != bwcs_pkg::st_boot);
  assign core_run = (s_q.st == bwcs_pkg::st_run);
  assign vec_load = s_q.vload;
  assign vec_addr = s_q.vaddr;
  assign sys_area = in_sys(prog_addr);
  assign user_space = !in_sys(prog_addr) && prog_addr != bwcs_pkg::RESET_VEC && prog_addr != bwcs_pkg::INT_VEC;
  assign xtal_en = s_q.xen;
  assign xtal_drv = s_q.xdrv;
  assign hrc_en = s_q.hen;
  // Slow clock kept alive while delays are timed
  assign lrc_en = s_q.len || !core_run;
  assign clk_src = s_q.src;
  assign clk_div = s_q.div;

  // ****************************************
  // Checks
  // ****************************************
  AST_WAKE_FAST: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && s_q.st == bwcs_pkg::st_wake && dly_done && s_q.wake_fast) |-> dly_cnt == 12'd44 ##1 core_run)
    else $error("fast wake count wrong");
  AST_WAKE_NORM: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && s_q.st == bwcs_pkg::st_wake && dly_done && !s_q.wake_fast) |-> dly_cnt == 12'd2999 ##1 core_run)
    else $error("normal wake count wrong");
  AST_BOOT_CNT: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && !core_rst_n && dly_done) |-> dly_cnt == (s_q.boot_fast ? 12'd44 : 12'd2999) ##1 core_rst_n)
    else $error("boot count wrong");
  AST_BOOT_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
    (!core_rst_n && !dly_done) |=> !core_rst_n)
    else $error("core released early");
  AST_RESET_VEC: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(core_rst_n) |-> vec_load && vec_addr == 11'h000)
    else $error("bad reset vector");
  AST_INT_VEC: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && core_run && int_take && !sleep_req) |=> vec_load && vec_addr == 11'h010)
    else $error("bad interrupt vector");
  AST_SYS_AREA: assert property (@(posedge mclk) disable iff (!rstn)
    (prog_addr >= 11'h7e0) |-> sys_area && !user_space)
    else $error("system area decode wrong");
  AST_XTAL_EN: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && core_rst_n && reg_wr && reg_addr == 8'h0a) |=> xtal_en == $past(reg_wdata[7]) || clk_src == 2'h2)
    else $error("crystal enable not taken");
  AST_BOOT_OSC: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(core_rst_n) |-> hrc_en && lrc_en)
    else $error("rc oscillators off after boot");
  AST_SRC_ON: assert property (@(posedge mclk) disable iff (!rstn)
    (clk_src == 2'h2 && xtal_en) || (clk_src == 2'h0 && hrc_en) || (clk_src == 2'h1 && s_q.len))
    else $error("selected oscillator disabled");
endmodule : bwcs_top

// [tb/bwcs_top_test.sv]
`timescale 1ns/1ps
module bwcs_top_test;
  // ****************************************
  // Signals
  // ****************************************
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic lrc_clk_in = 1'b0;
  logic boot_fast_pin = 1'b1;
  logic sleep_req = 1'b0;
  logic wake_evt = 1'b0;
  logic int_take = 1'b0;
  logic [10:0] prog_addr = 11'h000;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic core_rst_n, core_run, vec_load, sys_area, user_space, xtal_en, hrc_en, lrc_en;
  logic [10:0] vec_addr;
  logic [1:0] xtal_drv, clk_src;
  logic [2:0] clk_div;
  logic [7:0] rq[$];
  logic [10:0] vq[$];
  logic [15:0] r = 16'h004c;
  logic [7:0] xc = 8'h00;
  logic [7:0] cm = 8'h34;
  logic rd_p = 1'b0;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  // Source select refusals need the whole sequence in order
  logic [23:0] tbl [12] = '{24'h033634, 24'h0ae0e0, 24'h037676, 24'h037776, 24'h0a0080, 24'h031515,
    24'h030505, 24'h030405, 24'h0a0000, 24'h031515, 24'h033434, 24'h033030};
  logic [10:0] cor [6] = '{11'h000, 11'h010, 11'h7df, 11'h7e0, 11'h7ff, 11'h011};

  bwcs_top dut (.mclk(mclk), .rstn(rstn), .ce(ce), .lrc_clk_in(lrc_clk_in), .boot_fast_pin(boot_fast_pin),
    .sleep_req(sleep_req), .wake_evt(wake_evt), .int_take(int_take), .prog_addr(prog_addr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_rst_n(core_rst_n), .core_run(core_run), .vec_load(vec_load), .vec_addr(vec_addr),
    .sys_area(sys_area), .user_space(user_space), .xtal_en(xtal_en), .xtal_drv(xtal_drv),
    .hrc_en(hrc_en), .lrc_en(lrc_en), .clk_src(clk_src), .clk_div(clk_div));

  initial begin
    forever #10 mclk = ~mclk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask : rd

  task lrc(input int n);
    repeat (n) begin
      repeat (3) @(posedge mclk);
      lrc_clk_in <= 1'b1;
      repeat (3) @(posedge mclk);
      lrc_clk_in <= 1'b0;
    end
  endtask : lrc

  // One edge short must still hold, the last edge releases
  task boot(input int n);
    vq.push_back(bwcs_pkg::RESET_VEC);
    lrc(n - 1);
    repeat (8) @(negedge mclk);
    chk("core_rst_n", 11'(core_rst_n), 11'h0);
    lrc(1);
    repeat (8) @(negedge mclk);
    chk("core_rst_n", 11'(core_rst_n), 11'h1);
    chk("vec_addr", vec_addr, bwcs_pkg::RESET_VEC);
    chk("vec_seen", 11'(vq.size()), 11'h0);
  endtask : boot

  // Clock enable low must hold off the sleep request
  task nap(input int n);
    @(posedge mclk);
    ce <= 1'b0;
    sleep_req <= 1'b1;
    repeat (2) @(negedge mclk);
    chk("core_run", 11'(core_run), 11'h1);
    @(posedge mclk);
    ce <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
    @(negedge mclk);
    chk("core_run", 11'(core_run), 11'h0);
    chk("lrc_en", 11'(lrc_en), 11'h1);
    @(posedge mclk);
    wake_evt <= 1'b1;
    @(posedge mclk);
    wake_evt <= 1'b0;
    lrc(n - 1);
    repeat (8) @(negedge mclk);
    chk("core_run", 11'(core_run), 11'h0);
    lrc(1);
    repeat (8) @(negedge mclk);
    chk("core_run", 11'(core_run), 11'h1);
  endtask : nap

  // ****************************************
  // Monitors
  // ****************************************
  always @(posedge mclk) begin
    rd_p <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      err_total++;
      test_done();
    end
  end

  always @(negedge mclk) begin
    if (rd_p && rq.size() > 0) chk("reg_rdata", 11'(reg_rdata), 11'(rq.pop_front()));
    if (vec_load === 1'b1 && vq.size() > 0) chk("vec_addr", vec_addr, vq.pop_front());
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    chk("hrc_en", 11'(hrc_en), 11'h1);
    rd(bwcs_pkg::CLKMD_OFS, 8'h34);
    rd(bwcs_pkg::WAKEOPT_OFS, 8'h00);
    wr(bwcs_pkg::CLKMD_OFS, 8'h00);
    boot(bwcs_pkg::FAST_CNT);
    chk("lrc_en", 11'(lrc_en), 11'h1);
    rd(bwcs_pkg::CLKMD_OFS, 8'h34);
    rd(bwcs_pkg::STATUS_OFS, 8'h12);
    rd(8'h20, 8'h00);
    for (int i = 0; i < 12; i++) begin
      wr(tbl[i][23:16], tbl[i][15:8]);
      if (tbl[i][23:16] == bwcs_pkg::XCTL_OFS) xc = tbl[i][7:0];
      else cm = tbl[i][7:0];
      rd(tbl[i][23:16], tbl[i][7:0]);
      @(negedge mclk);
      chk("xtal_en", 11'(xtal_en), 11'(xc[7]));
      chk("xtal_drv", 11'(xtal_drv), 11'(xc[6:5]));
      chk("hrc_en", 11'(hrc_en), 11'(cm[4]));
      chk("lrc_en", 11'(lrc_en), 11'(cm[2]));
      chk("clk_src", 11'(clk_src), 11'(cm[1:0]));
      chk("clk_div", 11'(clk_div), 11'(cm[7:5]));
    end
    vq.push_back(bwcs_pkg::INT_VEC);
    @(posedge mclk);
    int_take <= 1'b1;
    @(posedge mclk);
    int_take <= 1'b0;
    repeat (3) @(negedge mclk);
    chk("int_seen", 11'(vq.size()), 11'h0);
    chk("vec_load", 11'(vec_load), 11'h0);
    wr(bwcs_pkg::WAKEOPT_OFS, 8'h01);
    nap(bwcs_pkg::FAST_CNT);
    wr(bwcs_pkg::WAKEOPT_OFS, 8'h00);
    nap(bwcs_pkg::NORM_CNT);
    for (int i = 0; i < 48; i++) begin
      r = lfsr(r);
      @(posedge mclk);
      prog_addr <= (i < 6) ? cor[i] : r[10:0];
      @(negedge mclk);
      chk("sys_area", 11'(sys_area), 11'(prog_addr >= 11'h7e0));
      chk("user_space", 11'(user_space), 11'(prog_addr < 11'h7e0 && prog_addr != 11'h000
        && prog_addr != 11'h010));
    end
    @(posedge mclk);
    rstn <= 1'b0;
    boot_fast_pin <= 1'b0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    chk("clk_src", 11'(clk_src), 11'h0);
    boot(bwcs_pkg::NORM_CNT);
    rd(bwcs_pkg::STATUS_OFS, 8'h02);
    rd(bwcs_pkg::CLKMD_OFS, 8'h34);
    repeat (3) @(posedge mclk);
    test_done();
  end
endmodule : bwcs_top_test
